// ==== verilog/iop_ports.sv ====
// I/O ports, external bus sequencer and APB register file
//
// The implementer's own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "iop_cfg.svh"
module iop_ports
	import iop_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic [15:0] address_lines,
	output logic address_lines_oe,
	input wire logic [7:0] data_lines_in,
	output logic [7:0] data_lines_out,
	output logic data_lines_oe,
	output logic rd_n,
	output logic wr_n,
	output logic strobe_oe,
	output logic opcode_fetch_flag,
	output logic off_chip_n,
	output logic port_e_op_strobe,
	input wire logic wait_n,
	output logic [7:0] latched_output_port,
	input wire logic [7:0] bidir_port_in,
	output logic [7:0] bidir_port_out,
	output logic [7:0] bidir_port_oe,
	input wire logic [7:0] control_capable_port_in,
	output logic [7:0] control_capable_port_out,
	output logic [7:0] control_capable_port_oe,
	input wire logic serial_acknowledge,
	input wire logic timer_flag_output,
	output logic [15:0] address_output_port,
	output logic [15:0] address_output_port_oe
);
	iop_state_t s_ff;
	iop_state_t nxt_s;
	logic [7:0] pb_sync_ff;
	logic [7:0] pc_sync_ff;
	logic wait_sync_ff;
	logic [7:0] pb_out_ff;
	logic [7:0] pb_oe_ff;
	logic [7:0] pc_out_ff;
	logic [7:0] pc_oe_ff;
	logic [15:0] pe_out_ff;
	logic [15:0] pe_oe_ff;
	logic [15:0] nxt_pe_out;
	logic [15:0] nxt_pe_oe;
	logic [7:0] nxt_pc_out;
	logic [7:0] nxt_pc_oe;
	logic wr_acc;
	logic rd_acc;
	logic is_external;
	logic hold_in;

	// Internal ROM and RAM are decoded away from the pins
	assign is_external = (s_ff.bus_addr > `IOP_ROM_LAST) &&
		(s_ff.bus_addr < `IOP_RAM_FIRST);
	assign wr_acc = psel && penable && pwrite;
	assign rd_acc = psel && penable && !pwrite;
	// Hold request only acts as control when line 7 is in function mode
	assign hold_in = !s_ff.fsel_c[7] && s_ff.pc_in[7];

	always_comb
	begin
		nxt_s = s_ff;
		nxt_s.pb_in = pb_sync_ff;
		nxt_s.pc_in = pc_sync_ff;
		nxt_s.wait_n = wait_sync_ff;
		nxt_s.hold_req = hold_in;
		nxt_s.pready = 1'b0;
		nxt_s.pslverr = 1'b0;
		nxt_s.pins.pe_stb = 1'b0;
		// Port B latches the pin value on its input lines
		for (int i = 0; i < 8; i++)
		begin
			if (s_ff.dir_b[i])
			begin
				nxt_s.pb_lat[i] = s_ff.pb_in[i];
			end
		end
		for (int i = 0; i < 8; i++)
		begin
			if (s_ff.fsel_c[i] || i == 2 || i == 7 || i < 2)
			begin
				if ((i < 2 && s_ff.fsel_c[i]) || i == 2 || i == 7)
				begin
					nxt_s.pc_lat[i] = s_ff.pc_in[i];
				end
			end
		end
		// Hold is granted only in IOP_IDLE, which includes the edge that starts a bus cycle
		if (s_ff.st == IOP_IDLE)
		begin
			nxt_s.hold_ack = s_ff.hold_req;
		end
		// APB access phase, one wait state
		if (psel && penable && !s_ff.pready)
		begin
			nxt_s.pready = 1'b1;
			nxt_s.prdata = 32'h0000_0000;
			case (paddr)
			`IOP_OFF_PORT_A:
			begin
				if (pwrite)
				begin
					nxt_s.pa = pwdata[7:0];
				end
				nxt_s.prdata[7:0] = s_ff.pa;
			end
			`IOP_OFF_PORT_B:
			begin
				if (pwrite)
				begin
					nxt_s.pb_lat = (pwdata[7:0] & ~s_ff.dir_b) |
						(s_ff.pb_lat & s_ff.dir_b);
				end
				nxt_s.prdata[7:0] = s_ff.pb_lat;
			end
			`IOP_OFF_PORT_C:
			begin
				if (pwrite)
				begin
					nxt_s.pc_lat = pwdata[7:0];
				end
				nxt_s.prdata[7:0] = s_ff.pc_lat;
			end
			`IOP_OFF_DIR_B:
			begin
				if (pwrite)
				begin
					nxt_s.dir_b = pwdata[7:0];
				end
			end
			`IOP_OFF_FSEL_C:
			begin
				if (pwrite)
				begin
					nxt_s.fsel_c = pwdata[7:0];
				end
			end
			`IOP_OFF_PE_MODE:
			begin
				if (pwrite && pwdata[1:0] != 2'h3)
				begin
					nxt_s.pe_mode = iop_pe_mode_t'(pwdata[1:0]);
				end
				nxt_s.prdata[1:0] = s_ff.pe_mode;
			end
			`IOP_OFF_PE_DATA:
			begin
				if (pwrite)
				begin
					nxt_s.pe_data = pwdata[15:0];
					nxt_s.pins.pe_stb = 1'b1;
				end
				nxt_s.prdata[15:0] = s_ff.pe_data;
			end
			`IOP_OFF_BUS_ADDR:
			begin
				if (pwrite && !s_ff.bus_busy)
				begin
					nxt_s.bus_addr = pwdata[15:0];
				end
				nxt_s.prdata[15:0] = s_ff.bus_addr;
			end
			`IOP_OFF_BUS_DATA:
			begin
				if (pwrite && !s_ff.bus_busy)
				begin
					nxt_s.bus_wdata = pwdata[7:0];
				end
				nxt_s.prdata[7:0] = s_ff.bus_rdata;
			end
			`IOP_OFF_BUS_CMD:
			begin
				if (pwrite && pwdata[`IOP_CMD_GO] && !s_ff.bus_busy)
				begin
					nxt_s.bus_write = pwdata[`IOP_CMD_WR];
					nxt_s.bus_fetch = pwdata[`IOP_CMD_FETCH] &&
						!pwdata[`IOP_CMD_WR];
					nxt_s.bus_busy = 1'b1;
				end
			end
			`IOP_OFF_STATUS:
			begin
				nxt_s.prdata[0] = s_ff.bus_busy;
				nxt_s.prdata[1] = s_ff.hold_ack;
				nxt_s.prdata[2] = is_external;
				nxt_s.prdata[3] = s_ff.halt;
			end
			`IOP_OFF_CTRL:
			begin
				if (pwrite)
				begin
					nxt_s.halt = pwdata[0];
				end
				nxt_s.prdata[0] = s_ff.halt;
			end
			default:
			begin
				nxt_s.pslverr = 1'b1;
			end
			endcase
		end
		// Bus sequencer, wait seen two cycles late
		case (s_ff.st)
		IOP_IDLE:
		begin
			if (s_ff.bus_busy && !s_ff.hold_ack && !s_ff.halt)
			begin
				if (is_external)
				begin
					nxt_s.st = IOP_T1;
				end
				else
				begin
					nxt_s.bus_busy = 1'b0;
				end
			end
		end
		IOP_T1:
		begin
			nxt_s.st = IOP_T2;
		end
		IOP_T2, IOP_WAIT:
		begin
			if (!s_ff.wait_n)
			begin
				nxt_s.st = IOP_WAIT;
			end
			else
			begin
				nxt_s.st = IOP_T3;
			end
		end
		IOP_T3:
		begin
			if (!s_ff.bus_write)
			begin
				nxt_s.bus_rdata = data_lines_in;
			end
			nxt_s.bus_busy = 1'b0;
			nxt_s.st = IOP_IDLE;
		end
		default:
		begin
			nxt_s.st = IOP_IDLE;
		end
		endcase
		// Pin images derived from the sequencer state
		nxt_s.pins.addr = {(nxt_s.pe_mode == IOP_PE_NIB) ? 4'h0 :
			nxt_s.bus_addr[15:12], nxt_s.bus_addr[11:0]};
		nxt_s.pins.addr_oe = !nxt_s.hold_ack &&
			(nxt_s.pe_mode != IOP_PE_OUT16);
		nxt_s.pins.data = nxt_s.bus_wdata;
		nxt_s.pins.data_oe = nxt_s.bus_write &&
			(nxt_s.st == IOP_T2 || nxt_s.st == IOP_WAIT ||
			nxt_s.st == IOP_T3);
		nxt_s.pins.wr_n = !(nxt_s.bus_write &&
			(nxt_s.st == IOP_T2 || nxt_s.st == IOP_WAIT));
		nxt_s.pins.rd_n = !(!nxt_s.bus_write &&
			(nxt_s.st == IOP_T2 || nxt_s.st == IOP_WAIT ||
			nxt_s.st == IOP_T3));
		nxt_s.pins.strobe_oe = !nxt_s.halt && !nxt_s.hold_ack;
		nxt_s.pins.fetch = nxt_s.bus_fetch && nxt_s.bus_busy;
		nxt_s.pins.ext_n = !(is_external && nxt_s.bus_busy);
	end

	// Port C pin drive, function mode when mode bit is zero
	always_comb
	begin
		nxt_pc_out = s_ff.pc_lat;
		nxt_pc_oe = 8'h7A;
		nxt_pc_oe[0] = !s_ff.fsel_c[0];
		nxt_pc_oe[1] = !s_ff.fsel_c[1];
		if (!s_ff.fsel_c[3])
		begin
			nxt_pc_out[3] = serial_acknowledge;
		end
		if (!s_ff.fsel_c[4])
		begin
			nxt_pc_out[4] = timer_flag_output;
		end
		if (!s_ff.fsel_c[5])
		begin
			nxt_pc_out[5] = !is_external;
		end
		if (!s_ff.fsel_c[6])
		begin
			nxt_pc_out[6] = s_ff.hold_ack;
		end
	end

	// Port E output lines by mode
	always_comb
	begin
		nxt_pe_out = nxt_s.pe_data;
		nxt_pe_oe = 16'h0000;
		case (nxt_s.pe_mode)
		IOP_PE_NIB:
		begin
			nxt_pe_oe = 16'hF000;
		end
		IOP_PE_OUT16:
		begin
			nxt_pe_oe = 16'hFFFF;
		end
		default:
		begin
			nxt_pe_oe = 16'h0000;
		end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s_ff <= '0;
			s_ff.st <= IOP_IDLE;
			s_ff.pe_mode <= IOP_PE_ADDR16;
			s_ff.dir_b <= `IOP_RST_DIR_B;
			s_ff.fsel_c <= `IOP_RST_FSEL_C;
			s_ff.wait_n <= 1'b1;
			s_ff.pins.rd_n <= 1'b1;
			s_ff.pins.wr_n <= 1'b1;
			s_ff.pins.ext_n <= 1'b1;
			pb_sync_ff <= 8'h00;
			pc_sync_ff <= 8'h00;
			wait_sync_ff <= 1'b1;
			pb_out_ff <= 8'h00;
			pb_oe_ff <= 8'h00;
			pc_out_ff <= 8'h00;
			pc_oe_ff <= `IOP_RST_PC_OE;
			pe_out_ff <= 16'h0000;
			pe_oe_ff <= 16'h0000;
		end
		else
		begin
			s_ff <= nxt_s;
			pb_sync_ff <= bidir_port_in;
			pc_sync_ff <= control_capable_port_in;
			wait_sync_ff <= wait_n;
			pb_out_ff <= nxt_s.pb_lat;
			pb_oe_ff <= ~nxt_s.dir_b;
			pc_out_ff <= nxt_pc_out;
			pc_oe_ff <= nxt_pc_oe;
			pe_out_ff <= nxt_pe_out;
			pe_oe_ff <= nxt_pe_oe;
		end
	end

	assign prdata = s_ff.prdata;
	assign pready = s_ff.pready;
	assign pslverr = s_ff.pslverr;
	assign address_lines = s_ff.pins.addr;
	assign address_lines_oe = s_ff.pins.addr_oe;
	assign data_lines_out = s_ff.pins.data;
	assign data_lines_oe = s_ff.pins.data_oe;
	assign rd_n = s_ff.pins.rd_n;
	assign wr_n = s_ff.pins.wr_n;
	assign strobe_oe = s_ff.pins.strobe_oe;
	assign opcode_fetch_flag = s_ff.pins.fetch;
	assign off_chip_n = s_ff.pins.ext_n;
	assign port_e_op_strobe = s_ff.pins.pe_stb;
	assign latched_output_port = s_ff.pa;
	assign bidir_port_out = pb_out_ff;
	assign bidir_port_oe = pb_oe_ff;
	assign control_capable_port_out = pc_out_ff;
	assign control_capable_port_oe = pc_oe_ff;
	assign address_output_port = pe_out_ff;
	assign address_output_port_oe = pe_oe_ff;
endmodule
`default_nettype wire

// ==== verilog/iop_cfg.svh ====
// Offsets, reset values, address bounds and command bits of the I/O port block
`ifndef IOP_CFG_SVH
`define IOP_CFG_SVH
`define IOP_OFF_PORT_A 12'h000
`define IOP_OFF_PORT_B 12'h004
`define IOP_OFF_PORT_C 12'h008
`define IOP_OFF_DIR_B 12'h00C
`define IOP_OFF_FSEL_C 12'h010
`define IOP_OFF_PE_MODE 12'h014
`define IOP_OFF_PE_DATA 12'h018
`define IOP_OFF_BUS_CMD 12'h01C
`define IOP_OFF_BUS_ADDR 12'h020
`define IOP_OFF_BUS_DATA 12'h024
`define IOP_OFF_STATUS 12'h028
`define IOP_OFF_CTRL 12'h02C
`define IOP_RST_DIR_B 8'hFF
`define IOP_RST_FSEL_C 8'hFF
`define IOP_RST_PC_OE 8'h78
`define IOP_ROM_LAST 16'h0FFF
`define IOP_RAM_FIRST 16'hFF80
`define IOP_CMD_RD 0
`define IOP_CMD_WR 1
`define IOP_CMD_FETCH 2
`define IOP_CMD_GO 3
`define IOP_PE_NIB_POS 12
`endif

// ==== verilog/iop_pkg.sv ====
// Types of the I/O port and external bus block
package iop_pkg;
	typedef enum logic [1:0] {IOP_PE_ADDR16, IOP_PE_NIB, IOP_PE_OUT16}
		iop_pe_mode_t;
	typedef enum {IOP_IDLE, IOP_T1, IOP_T2, IOP_WAIT, IOP_T3} iop_bus_st_t;
	typedef struct packed {
		logic [15:0] addr;
		logic addr_oe;
		logic [7:0] data;
		logic data_oe;
		logic rd_n;
		logic wr_n;
		logic strobe_oe;
		logic fetch;
		logic ext_n;
		logic pe_stb;
	} iop_bus_pins_t;
	typedef struct packed {
		iop_bus_st_t st;
		iop_pe_mode_t pe_mode;
		logic [7:0] pa;
		logic [7:0] pb_lat;
		logic [7:0] dir_b;
		logic [7:0] pc_lat;
		logic [7:0] fsel_c;
		logic [15:0] pe_data;
		logic [15:0] bus_addr;
		logic [7:0] bus_wdata;
		logic [7:0] bus_rdata;
		logic bus_write;
		logic bus_fetch;
		logic bus_busy;
		logic halt;
		logic hold_ack;
		logic [7:0] pb_in;
		logic [7:0] pc_in;
		logic wait_n;
		logic hold_req;
		iop_bus_pins_t pins;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} iop_state_t;
endpackage

// ==== tb/iop_ports_properties.sv ====
// Pin-level assertions for the I/O port block
`timescale 1ns/1ns
`default_nettype none
`include "iop_cfg.svh"
module iop_ports_properties
	import iop_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic pready,
	input wire logic [15:0] address_lines,
	input wire logic address_lines_oe,
	input wire logic data_lines_oe,
	input wire logic rd_n,
	input wire logic wr_n,
	input wire logic strobe_oe,
	input wire logic opcode_fetch_flag,
	input wire logic off_chip_n,
	input wire logic port_e_op_strobe,
	input wire logic wait_n,
	input wire logic [7:0] latched_output_port,
	input wire logic [15:0] address_output_port_oe
);
	logic wr_go;
	logic wr_pa;
	logic wr_pe;
	assign wr_go = psel && penable && pwrite && pready;
	assign wr_pa = wr_go && paddr == `IOP_OFF_PORT_A;
	assign wr_pe = wr_go && paddr == `IOP_OFF_PE_DATA;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	strobe_drive_a: assert property ((!rd_n || !wr_n) |-> strobe_oe)
		else $error("strobe active while floating");
	ext_range_a: assert property ((!rd_n || !wr_n) &&
		address_output_port_oe == 16'h0000 |-> !off_chip_n &&
		address_lines >= 16'h1000 && address_lines <= 16'hFF7F)
		else $error("external strobe outside external range");
	wr_data_a: assert property (!wr_n |-> data_lines_oe && address_lines_oe)
		else $error("write strobe without driven buses");
	rd_release_a: assert property (!rd_n |-> !data_lines_oe)
		else $error("data bus driven during read");
	addr_hold_a: assert property (!rd_n && !$past(rd_n)
		|-> $stable(address_lines))
		else $error("address moved during read strobe");
	nib_mask_a: assert property (address_output_port_oe == 16'hF000 &&
		address_lines_oe |-> address_lines[15:12] == 4'h0)
		else $error("nibble mode address not 12 bits");
	out16_float_a: assert property (
		(address_output_port_oe == 16'hFFFF) [*2] |-> !address_lines_oe)
		else $error("address bus driven in output mode");
	fetch_nowrite_a: assert property (opcode_fetch_flag |-> wr_n)
		else $error("write during opcode fetch");
	pe_strobe_a: assert property (port_e_op_strobe |-> wr_pe)
		else $error("port strobe without port write");
	pa_hold_a: assert property ($changed(latched_output_port)
		|-> wr_pa)
		else $error("latched port changed without write");
	cover property (!rd_n && !wait_n);
	cover property (!wr_n);
	cover property (opcode_fetch_flag && !rd_n);
	cover property (port_e_op_strobe);
endmodule
bind iop_ports iop_ports_properties u_props (.pclk, .presetn, .psel, .penable,
	.pwrite, .paddr, .pready, .address_lines, .address_lines_oe, .data_lines_oe,
	.rd_n, .wr_n, .strobe_oe, .opcode_fetch_flag, .off_chip_n,
	.port_e_op_strobe, .wait_n, .latched_output_port,
	.address_output_port_oe);
`default_nettype wire

// ==== tb/iop_ext_mem.sv ====
// External memory model with wait insertion
`timescale 1ns/1ns
`default_nettype none
module iop_ext_mem
	import iop_pkg::*;
(
	input wire logic pclk,
	input wire logic [15:0] address_lines,
	input wire logic [7:0] data_lines_out,
	input wire logic data_lines_oe,
	input wire logic rd_n,
	input wire logic wr_n,
	input wire logic strobe_oe,
	input wire logic off_chip_n,
	input wire logic [3:0] wait_len,
	output logic [7:0] data_lines_in,
	output logic wait_n,
	output logic [15:0] last_waddr,
	output logic [7:0] last_wdata
);
	logic [7:0] last_ff = 8'h00;
	logic [3:0] cnt_ff = 4'h0;
	logic rd_on;
	assign rd_on = strobe_oe && !rd_n;
	// Own byte while driven, data only under the read strobe, else a toggling pattern
	assign data_lines_in = data_lines_oe ? data_lines_out :
		rd_on ? address_lines[7:0] ^ 8'h5A : ~last_ff;
	// Wait raised from the off-chip flag, ahead of the sync delay
	assign wait_n = off_chip_n || cnt_ff >= wait_len;
	always @(posedge pclk)
	begin
		last_ff <= data_lines_in;
		if (off_chip_n)
			cnt_ff <= 4'h0;
		else if (cnt_ff != 4'hF)
			cnt_ff <= cnt_ff + 4'h1;
		if (strobe_oe && !wr_n && data_lines_oe)
		begin
			last_waddr <= address_lines;
			last_wdata <= data_lines_out;
		end
	end
endmodule
`default_nettype wire

// ==== tb/tb_iop_ports.sv ====
// Self-checking bench for the I/O port block
`timescale 1ns/1ns
`default_nettype none
`include "iop_cfg.svh"
module tb_iop_ports
	import iop_pkg::*;
;
	logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0;
	logic pwrite = 1'h0, serial_acknowledge = 1'h0, timer_flag_output = 1'h0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rdv;
	logic [15:0] address_lines, address_output_port, last_waddr;
	logic [15:0] address_output_port_oe;
	logic [7:0] data_lines_in, data_lines_out, latched_output_port, last_wdata;
	logic [7:0] bidir_port_out, bidir_port_oe, bidir_port_in = 8'h00;
	logic [7:0] control_capable_port_out, control_capable_port_oe;
	logic [7:0] control_capable_port_in = 8'h00;
	logic pready, pslverr, err, address_lines_oe, data_lines_oe, rd_n, wr_n;
	logic strobe_oe, opcode_fetch_flag, off_chip_n, port_e_op_strobe, wait_n;
	logic [3:0] wait_len = 4'h0;
	logic [15:0] adr [4] = '{16'h0FFF, 16'h1000, 16'hFF7F, 16'hFF80};
	int failures = 0, total_checks = 0, rd_cnt = 0, ext_cnt = 0;
	int fetch_cnt = 0, stb_cnt = 0, i, n0;
	iop_ports u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .address_lines, .address_lines_oe,
		.data_lines_in, .data_lines_out, .data_lines_oe, .rd_n, .wr_n,
		.strobe_oe, .opcode_fetch_flag, .off_chip_n, .port_e_op_strobe,
		.wait_n, .latched_output_port, .bidir_port_in, .bidir_port_out,
		.bidir_port_oe, .control_capable_port_in, .control_capable_port_out,
		.control_capable_port_oe, .serial_acknowledge, .timer_flag_output,
		.address_output_port, .address_output_port_oe);
	iop_ext_mem u_mem (.pclk, .address_lines, .data_lines_out, .data_lines_oe,
		.rd_n, .wr_n, .strobe_oe, .off_chip_n, .wait_len, .data_lines_in,
		.wait_n, .last_waddr, .last_wdata);
	initial
		forever #20 pclk = ~pclk;
	always @(posedge pclk)
	begin
		rd_cnt += int'(rd_n === 1'h0);
		ext_cnt += int'(off_chip_n === 1'h0);
		fetch_cnt += int'(opcode_fetch_flag === 1'h1);
		stb_cnt += int'(port_e_op_strobe === 1'h1);
	end
	task final_report();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			failures++;
			$display("wrong value at %0t: %h not %h", $time, seen, exp);
		end
	endtask
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		for (k = 0; k < 20; k++)
		begin
			@(posedge pclk);
			if (pready === 1'h1)
				break;
		end
		if (k == 20)
		begin
			failures++;
			final_report();
		end
		rdv = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(negedge pclk);
	endtask
	task bus(input logic [15:0] a, input logic [7:0] d, input logic [3:0] c);
		int k;
		apb(1'h1, `IOP_OFF_BUS_ADDR, 32'(a));
		apb(1'h1, `IOP_OFF_BUS_DATA, 32'(d));
		apb(1'h1, `IOP_OFF_BUS_CMD, 32'(c));
		for (k = 0; k < 40; k++)
		begin
			apb(1'h0, `IOP_OFF_STATUS, 32'h0);
			if (rdv[0] === 1'h0)
				break;
		end
		if (k == 40)
		begin
			failures++;
			final_report();
		end
		apb(1'h0, `IOP_OFF_BUS_DATA, 32'h0);
	endtask
	initial
	begin
		repeat (8) @(posedge pclk);
		chk({strobe_oe, address_lines_oe, data_lines_oe}, 3'h0);
		chk(bidir_port_oe, 8'h00);
		chk({control_capable_port_oe, control_capable_port_out}, 16'h7800);
		presetn <= 1'h1;
		apb(1'h1, `IOP_OFF_PORT_A, 32'h5A);
		apb(1'h1, `IOP_OFF_PORT_B, 32'hFF);
		apb(1'h0, `IOP_OFF_PORT_A, 32'h0);
		chk(latched_output_port, 8'h5A);
		apb(1'h1, `IOP_OFF_PORT_A, rdv + 32'h1);
		chk(latched_output_port, 8'h5B);
		apb(1'h0, 12'h030, 32'h0);
		chk(err, 1'h1);
		bidir_port_in <= 8'h3C;
		apb(1'h1, `IOP_OFF_DIR_B, 32'h0F);
		chk(bidir_port_oe, 8'hF0);
		apb(1'h1, `IOP_OFF_PORT_B, 32'hA5);
		chk(bidir_port_out & 8'hF0, 8'hA0);
		apb(1'h0, `IOP_OFF_PORT_B, 32'h0);
		chk(rdv & 32'h0F, 32'h0C);
		@(posedge pclk);
		serial_acknowledge <= 1'h1;
		timer_flag_output <= 1'h1;
		apb(1'h1, `IOP_OFF_FSEL_C, 32'h00);
		chk(control_capable_port_oe, 8'h7B);
		chk(control_capable_port_out & 8'h18, 8'h18);
		@(posedge pclk);
		control_capable_port_in <= 8'h80;
		repeat (6) @(negedge pclk);
		chk({control_capable_port_out[6], strobe_oe}, 2'h2);
		@(posedge pclk);
		control_capable_port_in <= 8'h00;
		apb(1'h1, `IOP_OFF_FSEL_C, 32'hFF);
		chk(control_capable_port_oe, 8'h78);
		apb(1'h1, `IOP_OFF_CTRL, 32'h1);
		chk(strobe_oe, 1'h0);
		apb(1'h1, `IOP_OFF_CTRL, 32'h0);
		for (i = 0; i < 4; i++)
		begin
			rd_cnt = 0;
			ext_cnt = 0;
			bus(adr[i], 8'h00, 4'h8);
			chk({ext_cnt > 0, rd_cnt > 0}, {2{i == 1 || i == 2}});
			if (i == 1 || i == 2)
				chk(rdv, 32'(adr[i][7:0] ^ 8'h5A));
			if (i == 2)
				n0 = rd_cnt;
		end
		wait_len = 4'h6;
		rd_cnt = 0;
		bus(16'h1234, 8'h00, 4'h8);
		chk(rd_cnt > n0, 1'h1);
		chk(rdv, 32'h6E);
		wait_len = 4'h0;
		bus(16'h2001, 8'h77, 4'hA);
		chk({last_waddr, last_wdata}, 24'h200177);
		fetch_cnt = 0;
		bus(16'h3003, 8'h00, 4'hC);
		chk(fetch_cnt > 0, 1'h1);
		apb(1'h1, `IOP_OFF_PE_MODE, 32'h2);
		stb_cnt = 0;
		apb(1'h1, `IOP_OFF_PE_DATA, 32'hBEEF);
		chk({address_output_port_oe, address_output_port},
			32'hFFFFBEEF);
		chk(stb_cnt > 0, 1'h1);
		apb(1'h1, `IOP_OFF_PORT_A, 32'h0);
		chk(address_output_port, 16'hBEEF);
		apb(1'h1, `IOP_OFF_PE_MODE, 32'h1);
		chk({address_output_port_oe, address_output_port[15:12]},
			20'hF000B);
		apb(1'h1, `IOP_OFF_PE_MODE, 32'h0);
		chk(address_output_port_oe, 16'h0000);
		final_report();
	end
endmodule
`default_nettype wire
